// file: cts_defs.svh
`ifndef CTS_DEFS_SVH
`define CTS_DEFS_SVH
// Sensor count and index bounds
`define CTS_NSENS 12
`define CTS_LAST_IDX 4'hb
// Shadow parameter map, byte addresses
`define CTS_SPM_DEPTH 32
`define CTS_A_EN_LO 5'h0c
`define CTS_A_EN_HI 5'h0d
`define CTS_A_SL_LO 5'h0e
`define CTS_A_SL_HI 5'h0f
`define CTS_A_THR 5'h10
`define CTS_A_HYS 5'h11
`define CTS_A_NPOS 5'h12
`define CTS_A_NNEG 5'h13
`define CTS_A_STEP 5'h14
`define CTS_A_PCOMP 5'h15
`define CTS_A_PER_ACT 5'h16
`define CTS_A_PER_DOZE 5'h17
`define CTS_A_RES 5'h18
// Fixed default set: six buttons and a six sensor slider
`define CTS_Q_SENS 8'h20
`define CTS_Q_EN_LO 8'hff
`define CTS_Q_EN_HI 8'h0f
`define CTS_Q_SL_LO 8'hc0
`define CTS_Q_SL_HI 8'h0f
`define CTS_Q_THR 8'h40
`define CTS_Q_HYS 8'h08
`define CTS_Q_NPOS 8'h20
`define CTS_Q_NNEG 8'h20
`define CTS_Q_STEP 8'h04
`define CTS_Q_PCOMP 8'h64
`define CTS_Q_PER_ACT 8'h1e
`define CTS_Q_PER_DOZE 8'hc3
`define CTS_Q_RES 8'h20
`define CTS_Q_NONE 8'h00
// Sequencing counts
`define CTS_LD_END 6'h20
`define CTS_BN_END 6'h1f
`define CTS_PASS_LAST 3'h7
`define CTS_AVG_SH 3
// Operating modes
`define CTS_MODE_DOZE 2'h1
`define CTS_MODE_SLEEP 2'h2
// Timing: one scan period unit and the clock period
`define CTS_MS_NS 1000000
`define CTS_CLK_NS 20
`endif

// file: cts_pkg.sv
package cts_pkg;
   typedef enum logic [2:0] {
      ST_LOAD = 3'h0,
      ST_IDLE = 3'h1,
      ST_SENSE = 3'h2,
      ST_WAIT = 3'h3,
      ST_PROC = 3'h4,
      ST_SLIDE = 3'h5,
      ST_BURN = 3'h6
   } cts_state_e;
   typedef logic signed [15:0] cts_tick_t;
endpackage : cts_pkg

// file: cts_scan_core.sv
`timescale 1ns/10ps
`include "cts_defs.svh"
// Operation
// - Lowest enabled slider sensor is position zero, highest is maximum.
// - Movement only when position changes by at least the step between scans.
// - Separate move-low and move-high events by direction.
// - Measure enabled sensors one at a time, storing each tick result.
// - Disabled sensors are skipped in sensing and processing.
// - Per-sensor sensitivity sets the accumulation cycle count.
// - Per-sensor 16-bit offset value goes to the front end.
// - Power-up estimates offsets driving ticks to zero, then uses them.
// - Offsets clear on reset; estimation restarts afterwards.
// - Average beyond positive or negative noise threshold restarts compensation.
// - Compensation also restarts after a configured number of scans.
// - Host compensation request accepted in Active or Doze mode.
// - Raw ticks are low-pass filtered into a per-sensor average.
// - Difference of raw and average drives sensor states and status.
// - Fixed default set for six buttons and slider runs without host.
// - At power-up use persistent store if valid, else fixed defaults.
// - Selected source is copied to shadow memory; logic uses only that.
// - Shadow memory reloads after every reset.
// - Host sees button, slider status and mode control.
// - Host may overwrite shadow parameters any time after load.
// - Host may have the persistent store written.
// - Store write copies shadow contents on host signal.
// - Touch at threshold plus hysteresis, release below threshold minus hysteresis.
// - Completion event pulses when compensation finishes.
module cts_scan_core import cts_pkg::*; #(
   parameter int MS_CYCLES = `CTS_MS_NS / `CTS_CLK_NS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Charge sensing front end
   output logic fe_start,
   output logic [3:0] fe_sel,
   output logic [7:0] fe_cycles,
   output logic [15:0] fe_offset,
   input wire logic fe_done,
   input wire logic [15:0] fe_ticks,
   // Persistent parameter store
   input wire logic nvm_valid,
   input wire logic [7:0] nvm_rdata,
   output logic [4:0] nvm_addr,
   output logic nvm_wr,
   output logic [7:0] nvm_wdata,
   // Host control
   input wire logic [1:0] host_mode,
   input wire logic host_comp_req,
   input wire logic host_spm_wr,
   input wire logic [4:0] host_spm_addr,
   input wire logic [7:0] host_spm_wdata,
   input wire logic host_burn_req,
   // Status
   output logic cfg_ready,
   output logic [11:0] button_stat,
   output logic slider_on,
   output logic [7:0] slider_pos,
   output logic move_high,
   output logic move_low,
   output logic comp_done,
   output logic burn_done
);

   // Default set, fixed in logic and never writable
   function automatic logic [7:0] rom_val(input logic [4:0] a);
      case (a)
         `CTS_A_EN_LO: rom_val = `CTS_Q_EN_LO;
         `CTS_A_EN_HI: rom_val = `CTS_Q_EN_HI;
         `CTS_A_SL_LO: rom_val = `CTS_Q_SL_LO;
         `CTS_A_SL_HI: rom_val = `CTS_Q_SL_HI;
         `CTS_A_THR: rom_val = `CTS_Q_THR;
         `CTS_A_HYS: rom_val = `CTS_Q_HYS;
         `CTS_A_NPOS: rom_val = `CTS_Q_NPOS;
         `CTS_A_NNEG: rom_val = `CTS_Q_NNEG;
         `CTS_A_STEP: rom_val = `CTS_Q_STEP;
         `CTS_A_PCOMP: rom_val = `CTS_Q_PCOMP;
         `CTS_A_PER_ACT: rom_val = `CTS_Q_PER_ACT;
         `CTS_A_PER_DOZE: rom_val = `CTS_Q_PER_DOZE;
         `CTS_A_RES: rom_val = `CTS_Q_RES;
         default: rom_val = (a < `CTS_A_EN_LO) ? `CTS_Q_SENS : `CTS_Q_NONE;
      endcase
   endfunction : rom_val

   logic [7:0] shadow_param_ram [0:`CTS_SPM_DEPTH-1];
   cts_tick_t raw [0:`CTS_NSENS-1];
   cts_tick_t avg [0:`CTS_NSENS-1];
   cts_tick_t off [0:`CTS_NSENS-1];
   cts_state_e st_reg;
   logic [3:0] idx_reg;
   logic [5:0] ld_reg;
   logic src_nvm_reg;
   logic [11:0] btn_reg;
   logic comp_pend_reg, comp_run_reg, burn_pend_reg;
   logic [2:0] pass_reg;
   logic [7:0] scan_cnt_reg, per_cnt_reg;
   logic [15:0] ms_cnt_reg;
   logic [3:0] sl_cnt_reg, best_rank_reg;
   cts_tick_t best_reg;

   // Decoded shadow fields
   logic [11:0] en_vec, sl_vec;
   logic [4:0] ix5, ld_m1;
   logic last, proc_en, scan_go, sense_end, pass_last, scan_due;
   cts_tick_t diff, avg_new;
   logic signed [16:0] d17, on_lvl, off_lvl, a17, npos, nneg;
   logic noise_hit, per_hit, host_ok, sl_any;
   logic [11:0] prod;
   logic [7:0] pos_calc, per_sel;
   assign en_vec = {shadow_param_ram[`CTS_A_EN_HI][3:0], shadow_param_ram[`CTS_A_EN_LO]};
   assign sl_vec = {shadow_param_ram[`CTS_A_SL_HI][3:0], shadow_param_ram[`CTS_A_SL_LO]} & en_vec;
   assign ix5 = {1'b0, idx_reg};
   assign ld_m1 = 5'(ld_reg - 6'h01);
   assign last = (idx_reg == `CTS_LAST_IDX);
   assign proc_en = (st_reg == ST_PROC) && en_vec[idx_reg];
   assign scan_go = (st_reg == ST_IDLE) && !burn_pend_reg && scan_due;
   assign sense_end = last && (((st_reg == ST_SENSE) && !en_vec[idx_reg]) || ((st_reg == ST_WAIT) && fe_done));
   assign pass_last = (pass_reg == `CTS_PASS_LAST);

   // Filter and hysteresis arithmetic, widened to keep the sign
   assign diff = raw[idx_reg] - avg[idx_reg];
   assign avg_new = avg[idx_reg] + (diff >>> `CTS_AVG_SH);
   assign d17 = {diff[15], diff};
   assign a17 = {avg_new[15], avg_new};
   assign on_lvl = {9'h000, shadow_param_ram[`CTS_A_THR]} + {9'h000, shadow_param_ram[`CTS_A_HYS]};
   assign off_lvl = {9'h000, shadow_param_ram[`CTS_A_THR]} - {9'h000, shadow_param_ram[`CTS_A_HYS]};
   assign npos = {9'h000, shadow_param_ram[`CTS_A_NPOS]};
   assign nneg = 17'sh00000 - {9'h000, shadow_param_ram[`CTS_A_NNEG]};

   // Compensation triggers
   assign noise_hit = proc_en && !comp_run_reg && ((a17 > npos) || (a17 < nneg));
   assign per_hit = (st_reg == ST_SLIDE) && (shadow_param_ram[`CTS_A_PCOMP] != `CTS_Q_NONE)
                    && (scan_cnt_reg >= shadow_param_ram[`CTS_A_PCOMP]);
   assign host_ok = host_comp_req && (host_mode != `CTS_MODE_SLEEP);

   // Slider position by rank of the strongest slider sensor
   assign sl_any = |(btn_reg & sl_vec);
   assign prod = best_rank_reg * shadow_param_ram[`CTS_A_RES];
   assign pos_calc = prod[7:0];
   assign per_sel = (host_mode == `CTS_MODE_DOZE) ? shadow_param_ram[`CTS_A_PER_DOZE] : shadow_param_ram[`CTS_A_PER_ACT];
   assign scan_due = cfg_ready && (host_mode != `CTS_MODE_SLEEP) && (per_cnt_reg >= per_sel);

   // Sequencer: load, scan, process, burn
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= ST_LOAD;
         idx_reg <= 4'h0;
         ld_reg <= 6'h00;
         src_nvm_reg <= 1'b0;
         cfg_ready <= 1'b0;
      end else begin
         case (st_reg)
            ST_LOAD: begin
               if (ld_reg == 6'h00) begin
                  src_nvm_reg <= nvm_valid;
               end
               ld_reg <= ld_reg + 6'h01;
               if (ld_reg == `CTS_LD_END) begin
                  st_reg <= ST_IDLE;
                  cfg_ready <= 1'b1;
               end
            end
            ST_IDLE: begin
               idx_reg <= 4'h0;
               ld_reg <= 6'h00;
               if (burn_pend_reg) begin
                  st_reg <= ST_BURN;
               end else if (scan_due) begin
                  st_reg <= ST_SENSE;
               end
            end
            ST_SENSE: begin
               if (en_vec[idx_reg]) begin
                  st_reg <= ST_WAIT;
               end else if (last) begin
                  idx_reg <= 4'h0;
                  st_reg <= !comp_run_reg ? ST_PROC : (pass_last ? ST_IDLE : ST_SENSE);
               end else begin
                  idx_reg <= idx_reg + 4'h1;
               end
            end
            ST_WAIT: begin
               if (fe_done && last) begin
                  idx_reg <= 4'h0;
                  st_reg <= !comp_run_reg ? ST_PROC : (pass_last ? ST_IDLE : ST_SENSE);
               end else if (fe_done) begin
                  idx_reg <= idx_reg + 4'h1;
                  st_reg <= ST_SENSE;
               end
            end
            ST_PROC: begin
               idx_reg <= idx_reg + 4'h1;
               if (last) begin
                  st_reg <= ST_SLIDE;
               end
            end
            ST_SLIDE: st_reg <= ST_IDLE;
            ST_BURN: begin
               ld_reg <= ld_reg + 6'h01;
               if (ld_reg == `CTS_BN_END) begin
                  st_reg <= ST_IDLE;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Shadow memory; left unreset, it is refilled after every reset
   always_ff @(posedge mclk) begin
      if (st_reg == ST_LOAD && ld_reg != 6'h00) begin
         shadow_param_ram[ld_m1] <= src_nvm_reg ? nvm_rdata : rom_val(ld_m1);
      end else if (host_spm_wr && cfg_ready) begin
         shadow_param_ram[host_spm_addr] <= host_spm_wdata;
      end
   end

   // Store port: read walk during load, write walk during burn
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nvm_addr <= 5'h00;
         nvm_wr <= 1'b0;
         nvm_wdata <= 8'h00;
         burn_done <= 1'b0;
      end else begin
         nvm_wr <= (st_reg == ST_BURN);
         burn_done <= (st_reg == ST_BURN) && (ld_reg == `CTS_BN_END);
         if (st_reg == ST_LOAD || st_reg == ST_BURN) begin
            nvm_addr <= ld_reg[4:0];
            nvm_wdata <= shadow_param_ram[ld_reg[4:0]];
         end
      end
   end

   // Front end request, one sensor at a time
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fe_start <= 1'b0;
         fe_sel <= 4'h0;
         fe_cycles <= 8'h00;
         fe_offset <= 16'h0000;
      end else begin
         fe_start <= (st_reg == ST_SENSE) && en_vec[idx_reg];
         if (st_reg == ST_SENSE) begin
            fe_sel <= idx_reg;
            fe_cycles <= shadow_param_ram[ix5];
            fe_offset <= off[idx_reg];
         end
      end
   end

   // Offsets start at zero and integrate residual ticks each pass
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `CTS_NSENS; i++) begin
            off[i] <= 16'sh0000;
         end
      end else if (st_reg == ST_WAIT && fe_done && comp_run_reg) begin
         off[idx_reg] <= off[idx_reg] + fe_ticks;
      end
   end

   // Compensation control; a new trigger wins over the take
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         comp_pend_reg <= 1'b1;
         comp_run_reg <= 1'b0;
         pass_reg <= 3'h0;
         comp_done <= 1'b0;
         scan_cnt_reg <= 8'h00;
      end else begin
         comp_done <= 1'b0;
         comp_pend_reg <= noise_hit || per_hit || host_ok || (comp_pend_reg && !scan_go);
         if (scan_go && comp_pend_reg) begin
            comp_run_reg <= 1'b1;
            pass_reg <= 3'h0;
            scan_cnt_reg <= 8'h00;
         end else if (sense_end && comp_run_reg) begin
            pass_reg <= pass_reg + 3'h1;
            if (pass_last) begin
               comp_run_reg <= 1'b0;
               comp_done <= 1'b1;
            end
         end else if (st_reg == ST_SLIDE && scan_cnt_reg != 8'hff) begin
            scan_cnt_reg <= scan_cnt_reg + 8'h01;
         end
      end
   end

   // Raw ticks and averages; both restart when compensation completes
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < `CTS_NSENS; i++) begin
            raw[i] <= 16'sh0000;
            avg[i] <= 16'sh0000;
         end
      end else if (comp_done) begin
         for (int i = 0; i < `CTS_NSENS; i++) begin
            raw[i] <= 16'sh0000;
            avg[i] <= 16'sh0000;
         end
      end else if (st_reg == ST_WAIT && fe_done && !comp_run_reg) begin
         raw[idx_reg] <= fe_ticks;
      end else if (proc_en) begin
         avg[idx_reg] <= avg_new;
      end
   end

   // Touch detection with hysteresis band
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         btn_reg <= 12'h000;
      end else if (st_reg == ST_PROC) begin
         if (!en_vec[idx_reg]) begin
            btn_reg[idx_reg] <= 1'b0;
         end else if (d17 >= on_lvl) begin
            btn_reg[idx_reg] <= 1'b1;
         end else if (d17 < off_lvl) begin
            btn_reg[idx_reg] <= 1'b0;
         end
      end
   end

   // Strongest slider sensor; rank counts enabled slider inputs only
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sl_cnt_reg <= 4'h0;
         best_rank_reg <= 4'h0;
         best_reg <= 16'sh0000;
      end else if (scan_go) begin
         sl_cnt_reg <= 4'h0;
      end else if (proc_en && sl_vec[idx_reg]) begin
         sl_cnt_reg <= sl_cnt_reg + 4'h1;
         if (sl_cnt_reg == 4'h0 || diff > best_reg) begin
            best_reg <= diff;
            best_rank_reg <= sl_cnt_reg;
         end
      end
   end

   // Status once per scan; moves compare with the previous scan
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         button_stat <= 12'h000;
         slider_on <= 1'b0;
         slider_pos <= 8'h00;
         move_high <= 1'b0;
         move_low <= 1'b0;
      end else begin
         move_high <= 1'b0;
         move_low <= 1'b0;
         if (st_reg == ST_SLIDE) begin
            button_stat <= btn_reg & ~sl_vec;
            slider_on <= sl_any;
            if (sl_any) begin
               slider_pos <= pos_calc;
               move_high <= slider_on && ({1'b0, pos_calc} >= {1'b0, slider_pos} + {1'b0, shadow_param_ram[`CTS_A_STEP]});
               move_low <= slider_on && ({1'b0, slider_pos} >= {1'b0, pos_calc} + {1'b0, shadow_param_ram[`CTS_A_STEP]});
            end
         end
      end
   end

   // Scan period timer from a millisecond enable
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ms_cnt_reg <= 16'h0000;
         per_cnt_reg <= 8'h00;
      end else begin
         ms_cnt_reg <= (ms_cnt_reg == 16'(MS_CYCLES - 1)) ? 16'h0000 : ms_cnt_reg + 16'h0001;
         if (scan_go) begin
            per_cnt_reg <= 8'h00;
         end else if (ms_cnt_reg == 16'(MS_CYCLES - 1) && per_cnt_reg != 8'hff) begin
            per_cnt_reg <= per_cnt_reg + 8'h01;
         end
      end
   end

   // Burn request held until the walk starts
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         burn_pend_reg <= 1'b0;
      end else begin
         burn_pend_reg <= (host_burn_req && cfg_ready) || (burn_pend_reg && st_reg != ST_IDLE);
      end
   end

   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_burn_run;
      nvm_wr [*8];
   endsequence
   sequence s_slide_tail;
      (st_reg == ST_SLIDE) ##1 (st_reg == ST_IDLE);
   endsequence
   a_start_enabled: assert property (fe_start |-> en_vec[fe_sel] && cfg_ready)
      else $error("request for disabled sensor");
   a_start_cycles: assert property (fe_start |-> fe_cycles == shadow_param_ram[{1'b0, fe_sel}])
      else $error("wrong accumulation count");
   a_start_offset: assert property (fe_start |-> fe_offset == off[fe_sel])
      else $error("wrong offset value");
   a_one_sensor: assert property (fe_start |-> st_reg == ST_WAIT ##1 !fe_start)
      else $error("second request while busy");
   a_offset_step: assert property (st_reg == ST_WAIT && fe_done && comp_run_reg
      |=> off[$past(idx_reg)] == $past(off[idx_reg]) + $past(fe_ticks))
      else $error("offset not integrated");
   a_noise_comp: assert property (noise_hit |=> comp_pend_reg)
      else $error("noise trigger lost");
   a_host_comp: assert property (host_ok |=> comp_pend_reg)
      else $error("host request lost");
   a_move_high: assert property (move_high |-> !move_low && {1'b0, slider_pos}
      >= {1'b0, $past(slider_pos)} + {1'b0, shadow_param_ram[`CTS_A_STEP]})
      else $error("move high below step");
   a_move_low: assert property (move_low |-> !move_high && {1'b0, $past(slider_pos)}
      >= {1'b0, slider_pos} + {1'b0, shadow_param_ram[`CTS_A_STEP]})
      else $error("move low below step");
   a_burn_walk: assert property ($rose(nvm_wr) |-> (nvm_addr == 5'h00) and s_burn_run)
      else $error("burn walk broken");
   a_proc_tail: assert property ((st_reg == ST_PROC && last) |=> s_slide_tail)
      else $error("status not published");
   a_comp_end: assert property (comp_done |-> !comp_run_reg ##1 avg[0] == 16'sh0000)
      else $error("completion without end");
endmodule : cts_scan_core

// file: cts_fe_model.sv
`timescale 1ns/10ps
// Front end and persistent store seen from the scan core
module cts_fe_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Front end request and answer
   input wire logic fe_start,
   input wire logic [3:0] fe_sel,
   input wire logic [15:0] fe_offset,
   input wire logic [11:0] touch,
   output logic fe_done,
   output logic [15:0] fe_ticks,
   // Store port
   input wire logic [4:0] nvm_addr,
   input wire logic nvm_wr,
   input wire logic [7:0] nvm_wdata,
   output logic [7:0] nvm_rdata
);
   logic [7:0] store [0:31];
   logic [3:0] sel_reg;
   logic [3:0] wait_cnt;
   logic busy;
   // Store starts blank and survives the core's reset
   initial begin
      for (int i = 0; i < 32; i++) store[i] = 8'h00;
   end
   always @(posedge mclk) begin
      if (nvm_wr) store[nvm_addr] <= nvm_wdata;
   end
   assign nvm_rdata = store[nvm_addr];
   // Latency varies per sensor, so slow and prompt answers both occur
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy <= 1'b0;
         fe_done <= 1'b0;
         fe_ticks <= 16'h0000;
         sel_reg <= 4'h0;
         wait_cnt <= 4'h0;
      end else begin
         fe_done <= 1'b0;
         if (fe_done) fe_ticks <= ~fe_ticks; // Stale word never repeats
         if (fe_start) begin
            busy <= 1'b1;
            sel_reg <= fe_sel;
            wait_cnt <= {2'h0, fe_sel[1:0]} + 4'h2;
         end else if (busy) begin
            if (wait_cnt == 4'h0) begin
               busy <= 1'b0;
               fe_done <= 1'b1;
               // Offset removed ahead of conversion
               fe_ticks <= {8'h01, sel_reg, 4'h0} + (touch[sel_reg] ? 16'h0060 : 16'h0000) - fe_offset;
            end else begin
               wait_cnt <= wait_cnt - 4'h1;
            end
         end
      end
   end
endmodule : cts_fe_model

// file: testbench.sv
`timescale 1ns/10ps
`include "cts_defs.svh"
module testbench;
   logic mclk = 1'b0, arst_n = 1'b0, nvm_valid = 1'b0;
   logic fe_start, fe_done, nvm_wr, cfg_ready, slider_on, move_high, move_low, comp_done, burn_done;
   logic [3:0] fe_sel;
   logic [7:0] fe_cycles, nvm_rdata, nvm_wdata, slider_pos;
   logic [15:0] fe_offset, fe_ticks;
   logic [4:0] nvm_addr;
   logic [11:0] button_stat, touch = 12'h000;
   logic [1:0] host_mode = 2'h0;
   logic host_comp_req = 1'b0, host_spm_wr = 1'b0, host_burn_req = 1'b0;
   logic [4:0] host_spm_addr = 5'h00;
   logic [7:0] host_spm_wdata = 8'h00;
   int n_mismatch = 0, checks_done = 0, cyc = 0, n_start, n_sel0, n_wr;
   logic mv_hi, mv_lo, comp_seen, burn_seen;
   cts_scan_core #(.MS_CYCLES(4)) dut (.mclk(mclk), .arst_n(arst_n), .fe_start(fe_start), .fe_sel(fe_sel),
      .fe_cycles(fe_cycles), .fe_offset(fe_offset), .fe_done(fe_done), .fe_ticks(fe_ticks),
      .nvm_valid(nvm_valid), .nvm_rdata(nvm_rdata), .nvm_addr(nvm_addr), .nvm_wr(nvm_wr),
      .nvm_wdata(nvm_wdata), .host_mode(host_mode), .host_comp_req(host_comp_req),
      .host_spm_wr(host_spm_wr), .host_spm_addr(host_spm_addr), .host_spm_wdata(host_spm_wdata),
      .host_burn_req(host_burn_req), .cfg_ready(cfg_ready), .button_stat(button_stat),
      .slider_on(slider_on), .slider_pos(slider_pos), .move_high(move_high), .move_low(move_low),
      .comp_done(comp_done), .burn_done(burn_done));
   cts_fe_model model (.mclk(mclk), .arst_n(arst_n), .fe_start(fe_start), .fe_sel(fe_sel),
      .fe_offset(fe_offset), .touch(touch), .fe_done(fe_done), .fe_ticks(fe_ticks),
      .nvm_addr(nvm_addr), .nvm_wr(nvm_wr), .nvm_wdata(nvm_wdata), .nvm_rdata(nvm_rdata));
   // 50 MHz clock
   always #10 mclk = ~mclk;
   // Sticky event flags and counters, so one-cycle pulses are never missed
   always @(posedge mclk) begin
      if (fe_start === 1'b1) n_start++;
      if (fe_start === 1'b1 && fe_sel === 4'h0) n_sel0++;
      if (move_high === 1'b1) mv_hi = 1'b1;
      if (move_low === 1'b1) mv_lo = 1'b1;
      if (comp_done === 1'b1) comp_seen = 1'b1;
      if (burn_done === 1'b1) burn_seen = 1'b1;
      if (nvm_wr === 1'b1) n_wr++;
   end
   // Watchdog well above the few thousand cycles the run needs
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: watchdog expired", $time);
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : step
   task automatic clear_flags();
      mv_hi = 1'b0;
      mv_lo = 1'b0;
      comp_seen = 1'b0;
      burn_seen = 1'b0;
      n_start = 0;
      n_sel0 = 0;
      n_wr = 0;
   endtask : clear_flags
   // Reset, then load must take exactly 33 edges; offsets start at zero
   task automatic do_reset(input logic valid);
      int n;
      arst_n = 1'b0;
      nvm_valid = valid;
      step(10);
      arst_n = 1'b1;
      clear_flags();
      n = 0;
      while (cfg_ready !== 1'b1) begin
         step(1);
         n++;
      end
      check(n, 33);
      @(posedge mclk iff fe_start === 1'b1);
      #1;
      check(fe_offset, 16'h0000);
      check(fe_cycles, valid ? 8'h33 : `CTS_Q_SENS);
   endtask : do_reset
   // Scan end: last sensor answered, then processing and publish cycles
   task automatic wait_scan();
      @(posedge mclk iff (fe_done === 1'b1 && fe_sel === `CTS_LAST_IDX));
      step(16);
   endtask : wait_scan
   task automatic spm_write(input logic [4:0] a, input logic [7:0] d);
      host_spm_addr = a;
      host_spm_wdata = d;
      host_spm_wr = 1'b1;
      step(1);
      host_spm_wr = 1'b0;
      // Idle gap so back-to-back writes never re-raise the strobe at once
      step(1);
   endtask : spm_write
   task automatic slide(input logic [11:0] t, input logic [7:0] pos, input logic hi, input logic lo);
      mv_hi = 1'b0;
      mv_lo = 1'b0;
      touch = t;
      wait_scan();
      check(slider_on, 1'b1);
      check(slider_pos, pos);
      check(mv_hi, hi);
      check(mv_lo, lo);
   endtask : slide
   initial begin
      do_reset(1'b0);
      wait (comp_seen === 1'b1);
      check(n_start, 96);
      @(posedge mclk iff fe_start === 1'b1);
      #1;
      check(fe_offset, {8'h01, fe_sel, 4'h0});
      $display("test power-up compensation done");
      touch = 12'h001;
      wait_scan();
      check(button_stat, 12'h001);
      check(slider_on, 1'b0);
      touch = 12'h000;
      wait_scan();
      check(button_stat, 12'h000);
      $display("test button done");
      slide(12'h100, 8'h40, 1'b0, 1'b0);
      slide(12'h400, 8'h80, 1'b1, 1'b0);
      slide(12'h040, 8'h00, 1'b0, 1'b1);
      spm_write(`CTS_A_STEP, 8'h50);
      slide(12'h100, 8'h40, 1'b0, 1'b0);
      touch = 12'h000;
      wait_scan();
      $display("test slider done");
      comp_seen = 1'b0;
      touch = 12'h001;
      wait (comp_seen === 1'b1);
      // Drift offset carries the held touch
      @(posedge mclk iff fe_start === 1'b1);
      #1;
      check(fe_sel, 4'h0);
      check(fe_offset, 16'h0160);
      touch = 12'h000;
      wait_scan();
      // Sleep neither scans nor keeps a request
      clear_flags();
      host_mode = `CTS_MODE_SLEEP;
      host_comp_req = 1'b1;
      step(1);
      host_comp_req = 1'b0;
      step(300);
      check(n_start, 0);
      host_mode = 2'h0;
      wait_scan();
      check(n_start, 12);
      // Doze request: the very next scan is the compensation run
      clear_flags();
      host_mode = `CTS_MODE_DOZE;
      host_comp_req = 1'b1;
      step(1);
      host_comp_req = 1'b0;
      wait (comp_seen === 1'b1);
      check(n_start, 96);
      $display("test drift and host compensation done");
      step(1);
      spm_write(`CTS_A_EN_LO, 8'hfe);
      spm_write(5'h01, 8'h33);
      host_mode = 2'h0;
      wait_scan();
      clear_flags();
      @(posedge mclk iff fe_start === 1'b1);
      #1;
      check(fe_sel, 4'h1);
      check(fe_cycles, 8'h33);
      wait_scan();
      check(n_sel0, 0);
      check(n_start, 11);
      $display("test disabled sensor done");
      clear_flags();
      host_burn_req = 1'b1;
      step(1);
      host_burn_req = 1'b0;
      wait (burn_seen === 1'b1);
      step(1);
      check(n_wr, 32);
      check(model.store[`CTS_A_EN_LO], 8'hfe);
      check(model.store[`CTS_A_STEP], 8'h50);
      $display("test store write done");
      do_reset(1'b1);
      wait (comp_seen === 1'b1);
      check(n_sel0, 0);
      check(n_start, 88);
      step(1);
      do_reset(1'b0);
      wait (comp_seen === 1'b1);
      check(n_start, 96);
      $display("test reload done");
      // Periodic compensation after one counted scan: two scans, then a run
      clear_flags();
      step(1);
      spm_write(`CTS_A_PCOMP, 8'h01);
      wait (comp_seen === 1'b1);
      check(n_start, 120);
      $display("test periodic compensation done");
      give_verdict();
   end
endmodule : testbench
